// ==== common/hbm_defs.svh ====
// offsets, field positions, reset values and sizes of the host bridge
// assumes nothing beyond being included once per compile unit
`ifndef HBM_DEFS_SVH
`define HBM_DEFS_SVH

`define HBM_COMM_FIRST    7'h00
`define HBM_COMM_LAST     7'h4f
`define HBM_CTRL_FIRST    7'h50
`define HBM_REG_PAGE_SEL  7'h7f
`define HBM_PAGE_SEL_BIT  0
`define HBM_PAGE_SEL_RST  8'h00
`define HBM_COMM_DEPTH    80
`define HBM_ADDR_RST      7'h00
`define HBM_PIN_IDLE      12'he00

`endif

// ==== common/hbm_pkg.sv ====
// types shared by the host bridge files
// assumes hbm_defs.svh supplies the numeric constants
package hbm_pkg;

  typedef logic [6:0] hbm_addr_t;
  typedef logic [7:0] hbm_byte_t;

  typedef enum logic [1:0] {
    HBM_RD_IDLE,
    HBM_RD_WAIT,
    HBM_RD_HOLD
  } hbm_rd_state_t;

endpackage

// ==== design/hbm_page_ram.sv ====
// one communication page: one write port, two registered read ports
// assumes addresses at or above the depth read as zero and never write
`timescale 1ns/1ps
`include "hbm_defs.svh"

module hbm_page_ram
  import hbm_pkg::*;
(
  // clock and reset
  input  wire logic      ref_clk,
  input  wire logic      rst_b,
  // write port
  input  wire logic      we,
  input  wire hbm_addr_t waddr,
  input  wire hbm_byte_t wdata,
  // read ports
  input  wire hbm_addr_t raddr_a,
  output hbm_byte_t      rdata_a,
  input  wire hbm_addr_t raddr_b,
  output hbm_byte_t      rdata_b
);

  hbm_byte_t mem [`HBM_COMM_DEPTH];
  hbm_byte_t nxt_rdata_a;
  hbm_byte_t nxt_rdata_b;

  function automatic logic in_range(input hbm_addr_t a);
    in_range = (a <= `HBM_COMM_LAST);
  endfunction

  always_comb begin
    nxt_rdata_a = 8'h00;
    nxt_rdata_b = 8'h00;
    if (in_range(raddr_a)) begin
      nxt_rdata_a = mem[raddr_a];
    end
    if (in_range(raddr_b)) begin
      nxt_rdata_b = mem[raddr_b];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (we && in_range(waddr)) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_a <= 8'h00;
      rdata_b <= 8'h00;
    end else begin
      rdata_a <= nxt_rdata_a;
      rdata_b <= nxt_rdata_b;
    end
  end

endmodule

// ==== design/hbm_bridge.sv ====
// host bridge front end: 8-bit parallel host port, indirect addressing,
// main and mirror communication pages, page select register
// assumes host pins are asynchronous and strobes last several ref_clk
// cycles; on-chip cpu port is synchronous to ref_clk
//
// What this block does
// - host reaches registers indirectly: address first, then data accesses
// - a byte with the select pin low is always an address byte
// - seven address bits select one of 128 bridge locations
// - 0x00-0x4f is the communication area, 0x50-0x7f control registers
// - page select bit 0 of 0x7f picks main or mirror page
// - host writes on main page are stored for the cpu
// - host reads on mirror page return data the cpu placed
// - host may only read the mirror page; its writes leave it alone
// - cpu writes only the mirror page, reads both, never alters main
// - cpu places results in mirror page, host then selects and reads
`timescale 1ns/1ps
`include "hbm_defs.svh"

module hbm_bridge
  import hbm_pkg::*;
(
  // clock and reset
  input  wire logic      ref_clk,
  input  wire logic      rst_b,
  // host parallel pins
  input  wire logic      host_cs_b,
  input  wire logic      host_wr_b,
  input  wire logic      host_rd_b,
  input  wire logic      cmd_addr_select_pin,
  input  wire hbm_byte_t host_data_in,
  output hbm_byte_t      host_data_out,
  output logic           host_data_oe,
  // on-chip cpu port
  input  wire logic      cpu_rd,
  input  wire logic      cpu_wr,
  input  wire logic      cpu_page,
  input  wire hbm_addr_t cpu_addr,
  input  wire hbm_byte_t cpu_wdata,
  output hbm_byte_t      cpu_rdata,
  output logic           cpu_rvalid,
  // page select state
  output hbm_byte_t      comm_page_select
);

  // pin synchronisers: cs, wr, rd, select, data
  logic [11:0] pin_s1_ff, pin_s2_ff, nxt_pin_s1, nxt_pin_s2;
  logic        cs_s2, wr_s2, rd_s2, sel_s2;
  hbm_byte_t   dat_s2;

  // host side state
  logic          wr_act_d_ff, nxt_wr_act_d;
  logic          rd_act_d_ff, nxt_rd_act_d;
  logic          held_sel_ff, nxt_held_sel;
  hbm_byte_t     held_dat_ff, nxt_held_dat;
  logic          rd_sel_ff,   nxt_rd_sel;
  hbm_addr_t     addr_ff,     nxt_addr;
  hbm_byte_t     page_sel_ff, nxt_page_sel;
  hbm_rd_state_t rd_st_ff,    nxt_rd_st;
  hbm_byte_t     dout_ff,     nxt_dout;
  logic          doe_ff,      nxt_doe;

  // cpu side state
  logic      cpu_rd_d_ff,   nxt_cpu_rd_d;
  logic      cpu_page_d_ff, nxt_cpu_page_d;
  logic      cpu_in_d_ff,   nxt_cpu_in_d;
  hbm_byte_t cpu_rdata_ff,  nxt_cpu_rdata;
  logic      cpu_rvalid_ff, nxt_cpu_rvalid;

  // decoded strobes and page read data
  logic      wr_act;
  logic      rd_act;
  logic      wr_end;
  logic      rd_start;
  logic      main_we;
  logic      mir_we;
  hbm_byte_t main_qa;
  hbm_byte_t main_qb;
  hbm_byte_t mir_qa;
  hbm_byte_t mir_qb;

  function automatic logic in_comm(input hbm_addr_t a);
    in_comm = (a <= `HBM_COMM_LAST);
  endfunction

  assign host_data_out    = dout_ff;
  assign host_data_oe     = doe_ff;
  assign cpu_rdata        = cpu_rdata_ff;
  assign cpu_rvalid       = cpu_rvalid_ff;
  assign comm_page_select = page_sel_ff;

  // synchronisers: stage one feeds only stage two
  assign {cs_s2, wr_s2, rd_s2, sel_s2, dat_s2} = pin_s2_ff;

  always_comb begin
    nxt_pin_s1 = {host_cs_b, host_wr_b, host_rd_b, cmd_addr_select_pin,
                  host_data_in};
    nxt_pin_s2 = pin_s1_ff;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_ff <= `HBM_PIN_IDLE;
      pin_s2_ff <= `HBM_PIN_IDLE;
    end else begin
      pin_s1_ff <= nxt_pin_s1;
      pin_s2_ff <= nxt_pin_s2;
    end
  end

  // write acts at strobe end, using values held while it was low
  assign wr_act   = !cs_s2 && !wr_s2;
  assign rd_act   = !cs_s2 && !rd_s2 && wr_s2;
  assign wr_end   = wr_act_d_ff && !wr_act;
  assign rd_start = rd_act && !rd_act_d_ff;

  assign main_we = wr_end && held_sel_ff && in_comm(addr_ff) &&
                   !page_sel_ff[`HBM_PAGE_SEL_BIT];
  assign mir_we  = cpu_wr && in_comm(cpu_addr);

  always_comb begin
    nxt_wr_act_d = wr_act;
    nxt_rd_act_d = rd_act;
    nxt_held_sel = held_sel_ff;
    nxt_held_dat = held_dat_ff;
    nxt_addr     = addr_ff;
    nxt_page_sel = page_sel_ff;
    if (wr_act) begin
      nxt_held_sel = sel_s2;
      nxt_held_dat = dat_s2;
    end
    if (wr_end) begin
      if (!held_sel_ff) begin
        nxt_addr = held_dat_ff[6:0];
      end else if (addr_ff == `HBM_REG_PAGE_SEL) begin
        nxt_page_sel = held_dat_ff;
      end
    end
  end

  // host read sequencer
  always_comb begin
    nxt_rd_st = rd_st_ff;
    nxt_dout  = dout_ff;
    nxt_rd_sel = rd_sel_ff;
    nxt_doe   = rd_act && (rd_st_ff != HBM_RD_IDLE);
    case (rd_st_ff)
      HBM_RD_IDLE: begin
        if (rd_start) begin
          nxt_rd_sel = sel_s2;
          nxt_rd_st = HBM_RD_WAIT;
        end
      end
      HBM_RD_WAIT: begin
        nxt_rd_st = HBM_RD_HOLD;
        if (!rd_sel_ff) begin
          nxt_dout = {1'b0, addr_ff};
        end else if (addr_ff == `HBM_REG_PAGE_SEL) begin
          nxt_dout = page_sel_ff;
        end else if (in_comm(addr_ff)) begin
          if (page_sel_ff[`HBM_PAGE_SEL_BIT]) begin
            nxt_dout = mir_qa;
          end else begin
            nxt_dout = main_qa;
          end
        end else begin
          nxt_dout = 8'h00;
        end
      end
      HBM_RD_HOLD: begin
        if (!rd_act) begin
          nxt_rd_st = HBM_RD_IDLE;
        end
      end
      default: begin
        nxt_rd_st = HBM_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_act_d_ff <= 1'b0;
      rd_act_d_ff <= 1'b0;
      held_sel_ff <= 1'b0;
      held_dat_ff <= 8'h00;
      rd_sel_ff   <= 1'b0;
      addr_ff     <= `HBM_ADDR_RST;
      page_sel_ff <= `HBM_PAGE_SEL_RST;
      rd_st_ff    <= HBM_RD_IDLE;
      dout_ff     <= 8'h00;
      doe_ff      <= 1'b0;
    end else begin
      wr_act_d_ff <= nxt_wr_act_d;
      rd_act_d_ff <= nxt_rd_act_d;
      held_sel_ff <= nxt_held_sel;
      held_dat_ff <= nxt_held_dat;
      rd_sel_ff   <= nxt_rd_sel;
      addr_ff     <= nxt_addr;
      page_sel_ff <= nxt_page_sel;
      rd_st_ff    <= nxt_rd_st;
      dout_ff     <= nxt_dout;
      doe_ff      <= nxt_doe;
    end
  end

  // cpu read path, two cycles to valid
  always_comb begin
    nxt_cpu_rd_d   = cpu_rd;
    nxt_cpu_page_d = cpu_page;
    nxt_cpu_in_d   = in_comm(cpu_addr);
    nxt_cpu_rvalid = cpu_rd_d_ff;
    nxt_cpu_rdata  = cpu_rdata_ff;
    if (cpu_rd_d_ff) begin
      if (!cpu_in_d_ff) begin
        nxt_cpu_rdata = 8'h00;
      end else if (cpu_page_d_ff) begin
        nxt_cpu_rdata = mir_qb;
      end else begin
        nxt_cpu_rdata = main_qb;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_rd_d_ff   <= 1'b0;
      cpu_page_d_ff <= 1'b0;
      cpu_in_d_ff   <= 1'b0;
      cpu_rdata_ff  <= 8'h00;
      cpu_rvalid_ff <= 1'b0;
    end else begin
      cpu_rd_d_ff   <= nxt_cpu_rd_d;
      cpu_page_d_ff <= nxt_cpu_page_d;
      cpu_in_d_ff   <= nxt_cpu_in_d;
      cpu_rdata_ff  <= nxt_cpu_rdata;
      cpu_rvalid_ff <= nxt_cpu_rvalid;
    end
  end

  // main page: host writes, both sides read
  hbm_page_ram u_main (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .we      (main_we),
    .waddr   (addr_ff),
    .wdata   (held_dat_ff),
    .raddr_a (addr_ff),
    .rdata_a (main_qa),
    .raddr_b (cpu_addr),
    .rdata_b (main_qb)
  );

  // mirror page: cpu writes, both sides read
  hbm_page_ram u_mirror (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .we      (mir_we),
    .waddr   (cpu_addr),
    .wdata   (cpu_wdata),
    .raddr_a (addr_ff),
    .rdata_a (mir_qa),
    .raddr_b (cpu_addr),
    .rdata_b (mir_qb)
  );

  property p_addr_take;
    @(posedge ref_clk) disable iff (!rst_b)
    (wr_end && !held_sel_ff) |=> (addr_ff == $past(held_dat_ff[6:0]));
  endproperty
  a_addr_take: assert property (p_addr_take)
    else $error("address byte not taken");
  property p_page_write;
    @(posedge ref_clk) disable iff (!rst_b)
    (wr_end && held_sel_ff && addr_ff == 7'h7f)
      |=> (page_sel_ff == $past(held_dat_ff));
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("page select not written");
  property p_main_store;
    @(posedge ref_clk) disable iff (!rst_b)
    (wr_end && held_sel_ff && addr_ff < 7'h50 && !page_sel_ff[0])
      |=> (u_main.mem[$past(addr_ff)] == $past(held_dat_ff));
  endproperty
  a_main_store: assert property (p_main_store)
    else $error("main page write lost");
  property p_mirror_ro;
    @(posedge ref_clk) disable iff (!rst_b)
    (wr_end && held_sel_ff && in_comm(addr_ff) && page_sel_ff[0] && !mir_we)
      |=> (u_mirror.mem[$past(addr_ff)] == $past(u_mirror.mem[addr_ff]));
  endproperty
  a_mirror_ro: assert property (p_mirror_ro)
    else $error("mirror changed by host write");
  property p_cpu_no_main;
    @(posedge ref_clk) disable iff (!rst_b)
    (cpu_wr && in_comm(cpu_addr) && !main_we)
      |=> (u_main.mem[$past(cpu_addr)] == $past(u_main.mem[cpu_addr]));
  endproperty
  a_cpu_no_main: assert property (p_cpu_no_main)
    else $error("main page changed by cpu write");
  property p_ctrl_zero;
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_st_ff == HBM_RD_WAIT && rd_sel_ff && addr_ff >= 7'h50 &&
     addr_ff != 7'h7f) |=> (dout_ff == 8'h00);
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero)
    else $error("control area read not zero");
  property p_mirror_read;
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_st_ff == HBM_RD_WAIT && rd_sel_ff && addr_ff < 7'h50 &&
     page_sel_ff[0]) |=> (dout_ff == $past(mir_qa));
  endproperty
  a_mirror_read: assert property (p_mirror_read)
    else $error("mirror read wrong data");
  property p_cpu_read;
    @(posedge ref_clk) disable iff (!rst_b)
    cpu_rd |-> ##2 cpu_rvalid_ff;
  endproperty
  a_cpu_read: assert property (p_cpu_read)
    else $error("cpu read not answered");
  property p_read_drive;
    @(posedge ref_clk) disable iff (!rst_b)
    (rd_start && rd_st_ff == HBM_RD_IDLE) ##1 rd_act |=> doe_ff;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("data bus not driven on read");

endmodule

// ==== dv/hbm_host_model.sv ====
// host processor model on the bridge's 8-bit parallel pins
// assumes xfer is called just after a ref_clk rising edge
`timescale 1ns/1ps

module hbm_host_model
  import hbm_pkg::*;
(
  // clock
  input  wire logic      ref_clk,
  // host pins
  output logic           host_cs_b,
  output logic           host_wr_b,
  output logic           host_rd_b,
  output logic           cmd_addr_select_pin,
  output hbm_byte_t      host_data_in,
  input  wire hbm_byte_t host_data_out,
  input  wire logic      host_data_oe
);
  logic      drv_en;
  hbm_byte_t drv_val;
  hbm_byte_t last_q;

  // released bus has no keeper: show a changing pattern
  assign host_data_in = drv_en ? drv_val :
                        host_data_oe ? host_data_out : ~last_q;

  always @(posedge ref_clk) begin
    last_q <= host_data_in;
  end

  initial begin
    host_cs_b = 1'b1;
    host_wr_b = 1'b1;
    host_rd_b = 1'b1;
    cmd_addr_select_pin = 1'b1;
    drv_en = 1'b0;
    drv_val = 8'h00;
    last_q = 8'h00;
  end

  // select low marks address
  // strobe 8 cycles low, 7 high; data and select held 3 past it
  task automatic xfer(input logic wr, input logic sel,
                      input hbm_byte_t d, output hbm_byte_t q);
    @(posedge ref_clk);
    cmd_addr_select_pin <= sel;
    drv_en <= wr;
    drv_val <= d;
    host_cs_b <= 1'b0;
    host_wr_b <= ~wr;
    host_rd_b <= wr;
    repeat (7) @(posedge ref_clk);
    #1 q = host_data_in;
    @(posedge ref_clk);
    host_cs_b <= 1'b1;
    host_wr_b <= 1'b1;
    host_rd_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    drv_en <= 1'b0;
    cmd_addr_select_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule

// ==== dv/tb_host_bridge_mailbox_pages.sv ====
// self-checking bench: host model on the pins, cpu port driven here
// assumes hbm_defs.svh is on the include path
`timescale 1ns/1ps
`include "hbm_defs.svh"

module tb_host_bridge_mailbox_pages
  import hbm_pkg::*;
;
  logic      ref_clk;
  logic      rst_b;
  logic      host_cs_b;
  logic      host_wr_b;
  logic      host_rd_b;
  logic      cmd_addr_select_pin;
  hbm_byte_t host_data_in;
  hbm_byte_t host_data_out;
  logic      host_data_oe;
  logic      cpu_rd;
  logic      cpu_wr;
  logic      cpu_page;
  hbm_addr_t cpu_addr;
  hbm_byte_t cpu_wdata;
  hbm_byte_t cpu_rdata;
  logic      cpu_rvalid;
  hbm_byte_t comm_page_select;
  int        errors;
  int        total_checks;
  int        cyc_cnt;
  int        seed;
  hbm_byte_t main_m [`HBM_COMM_DEPTH];
  hbm_byte_t mirr_m [`HBM_COMM_DEPTH];
  hbm_byte_t page_m;
  hbm_byte_t q;
  hbm_byte_t d;

  hbm_bridge dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .host_cs_b(host_cs_b),
    .host_wr_b(host_wr_b), .host_rd_b(host_rd_b),
    .cmd_addr_select_pin(cmd_addr_select_pin),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_page(cpu_page), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .comm_page_select(comm_page_select)
  );

  hbm_host_model host (
    .ref_clk(ref_clk), .host_cs_b(host_cs_b), .host_wr_b(host_wr_b),
    .host_rd_b(host_rd_b), .cmd_addr_select_pin(cmd_addr_select_pin),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe)
  );

  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input hbm_byte_t seen, input hbm_byte_t exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  function automatic hbm_byte_t exp_host(hbm_addr_t a);
    if (a <= `HBM_COMM_LAST)
      return page_m[`HBM_PAGE_SEL_BIT] ? mirr_m[a] : main_m[a];
    if (a == `HBM_REG_PAGE_SEL)
      return page_m;
    return 8'h00;
  endfunction

  function automatic hbm_byte_t exp_cpu(logic pg, hbm_addr_t a);
    if (a > `HBM_COMM_LAST)
      return 8'h00;
    return pg ? mirr_m[a] : main_m[a];
  endfunction

  // address byte, top bit random since it is ignored
  task automatic h_adr(input hbm_addr_t a);
    hbm_byte_t b;
    b = 8'($random(seed));
    host.xfer(1'b1, 1'b0, {b[7], a}, b);
  endtask

  task automatic h_wr(input hbm_addr_t a, input hbm_byte_t v);
    h_adr(a);
    host.xfer(1'b1, 1'b1, v, q);
    if (a == `HBM_REG_PAGE_SEL)
      page_m = v;
    else if (a <= `HBM_COMM_LAST && !page_m[`HBM_PAGE_SEL_BIT])
      main_m[a] = v;
  endtask

  task automatic h_rd(input hbm_addr_t a);
    h_adr(a);
    host.xfer(1'b0, 1'b1, 8'h00, q);
    check(q, exp_host(a));
  endtask

  task automatic c_wr(input hbm_addr_t a, input hbm_byte_t v);
    @(posedge ref_clk);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= v;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
    if (a <= `HBM_COMM_LAST)
      mirr_m[a] = v;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic c_rd(input logic pg, input hbm_addr_t a);
    @(posedge ref_clk);
    cpu_rd <= 1'b1;
    cpu_page <= pg;
    cpu_addr <= a;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    @(posedge ref_clk);
    #1 check({7'h00, cpu_rvalid}, 8'h01);
    check(cpu_rdata, exp_cpu(pg, a));
  endtask

  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_page = 1'b0;
    cpu_addr = 7'h00;
    cpu_wdata = 8'h00;
    errors = 0;
    total_checks = 0;
    cyc_cnt = 0;
    seed = 44;
    page_m = `HBM_PAGE_SEL_RST;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 check(comm_page_select, `HBM_PAGE_SEL_RST);
    check({7'h00, host_data_oe}, 8'h00);
    // host commands fill the main page, cpu results the mirror
    for (int i = 0; i < `HBM_COMM_DEPTH; i++) begin
      h_wr(7'(i), 8'($random(seed)));
    end
    for (int i = 0; i < `HBM_COMM_DEPTH; i++) begin
      c_wr(7'(i), 8'($random(seed)));
    end
    c_wr(7'h50, 8'h5a);
    for (int i = 0; i < `HBM_COMM_DEPTH; i++) begin
      c_rd(1'b0, 7'(i));
      c_rd(1'b1, 7'(i));
    end
    c_rd(1'b1, 7'h50);
    c_rd(1'b0, 7'h7f);
    h_rd(7'h00);
    h_rd(7'h4f);
    h_rd(7'h50);
    h_rd(7'h7f);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      h_adr(d[6:0]);
      host.xfer(1'b0, 1'b0, 8'h00, q);
      check(q, {1'b0, d[6:0]});
      h_rd(7'(d % 80));
    end
    // one address, two data bytes, no increment
    h_wr(7'h10, 8'h11);
    host.xfer(1'b1, 1'b1, 8'h33, q);
    main_m[16] = 8'h33;
    c_rd(1'b0, 7'h10);
    c_rd(1'b0, 7'h11);
    h_wr(7'h50, 8'hff);
    h_rd(7'h50);
    h_wr(7'h7f, 8'ha5);
    #1 check(comm_page_select, 8'ha5);
    h_rd(7'h7f);
    h_rd(7'h4f);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      h_rd(7'(d % 80));
    end
    h_wr(7'h20, ~mirr_m[32]);
    h_rd(7'h20);
    c_rd(1'b0, 7'h20);
    c_rd(1'b1, 7'h20);
    h_wr(7'h7f, 8'h5a);
    h_rd(7'h20);
    test_done();
  end
endmodule
